// [verilog/sdbt_timer.sv]
// Split-mode dual byte timer with APB register slave
//
// What this block does
// - Prescale codes 0-7 divide clock 1..1024
// - Enable bit zero stops all counting
// - Compare enable drives waveform pin
// - Idle level bits drive outputs when disabled
// - Split select turns on two byte counters
// - Command field: none, update, restart, reset
// - Command field always reads zero
// - Hard reset ignored while timer enabled
// - Clear register writes one clear status
// - Set register writes one set status
// - Both command registers read same status
// - Bits 6:4 enable compare interrupts
// - Bits 1:0 enable underflow interrupts
// - Low compare flag set on value match
// - Flags clear only by writing one or by hard reset
// - High underflow sets flag bit 1
// - Low underflow sets flag bit 0
`timescale 1ns/1ps
module sdbt_timer
    import sdbt_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  port_out,
    output logic      [5:0]  waveform_pin,
    output logic             update_pulse,
    output logic             irq
);
    // ***************************************************
    // Register state
    // ***************************************************
    sdbt_clken_s clken_r;
    logic [7:0]  cmpen_r;
    logic [7:0]  oval_r;
    logic        split_r;
    logic [7:0]  stat_r;
    logic [7:0]  inten_r;
    logic [7:0]  flags_r;
    logic [7:0]  cnt_r [2];
    logic [7:0]  per_r [2];
    logic [7:0]  cmp_r [6];
    logic [9:0]  presc_r;
    logic [5:0]  wg_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [5:0]  pin_r;
    logic        upd_r;
    logic        irq_r;

    // ***************************************************
    // APB decode
    // ***************************************************
    logic [5:0]  ix;
    logic        cmp_hit_ix;
    logic [2:0]  cmp_ch;
    logic        mapped;
    logic        fire;
    logic        wr;
    logic [7:0]  wd;
    logic [1:0]  cmd;
    logic        cmd_wr;
    logic        do_restart;
    logic        do_hard;
    logic        running;
    logic        tick;
    logic [1:0]  unf;
    logic [2:0]  lmatch;
    logic [7:0]  flags_nxt;
    logic [7:0]  rd_val;

    assign ix   = paddr[7:2];
    assign wd   = pwdata[7:0];
    assign fire = psel & penable & pready_r;
    assign wr   = fire & pwrite & mapped;

    // Which compare register an index hits
    always_comb begin
        cmp_hit_ix = 1'b0;
        cmp_ch     = 3'h0;
        for (int n = 0; n < 3; n++) begin
            if (ix == SDBT_IX_LOW_CMP + 6'(n) * SDBT_IX_CSTEP) begin
                cmp_hit_ix = 1'b1;
                cmp_ch     = 3'(n);
            end
            if (ix == SDBT_IX_HCMP + 6'(n) * SDBT_IX_CSTEP) begin
                cmp_hit_ix = 1'b1;
                cmp_ch     = 3'(n + 3);
            end
        end
    end

    // Address map check; misaligned is unmapped
    always_comb begin
        case (ix)
            SDBT_IX_CLKEN, SDBT_IX_CMPEN, SDBT_IX_OVAL,
            SDBT_IX_SPLIT, SDBT_IX_CLR, SDBT_IX_SET,
            SDBT_IX_INTEN, SDBT_IX_FLAGS, SDBT_IX_LOW_CNT,
            SDBT_IX_HCNT, SDBT_IX_LPER, SDBT_IX_HPER:
                mapped = (paddr[1:0] == 2'h0);
            default:
                mapped = cmp_hit_ix & (paddr[1:0] == 2'h0);
        endcase
    end

    // Read multiplexer
    always_comb begin
        case (ix)
            SDBT_IX_CLKEN: rd_val = clken_r & SDBT_M_CLKEN;
            SDBT_IX_CMPEN: rd_val = cmpen_r;
            SDBT_IX_OVAL:  rd_val = oval_r;
            SDBT_IX_SPLIT: rd_val = {7'h00, split_r};
            SDBT_IX_CLR,
            SDBT_IX_SET:   rd_val = stat_r;
            SDBT_IX_INTEN: rd_val = inten_r;
            SDBT_IX_FLAGS: rd_val = flags_r;
            SDBT_IX_LOW_CNT: rd_val = cnt_r[0];
            SDBT_IX_HCNT:  rd_val = cnt_r[1];
            SDBT_IX_LPER:  rd_val = per_r[0];
            SDBT_IX_HPER:  rd_val = per_r[1];
            default:       rd_val = cmp_hit_ix ? cmp_r[cmp_ch] : 8'h00;
        endcase
    end

    // Two-cycle access: pready one cycle after access
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
            if (psel & penable & ~pready_r) begin
                prdata_r <= (mapped & ~pwrite) ? {24'h00_0000, rd_val}
                                               : 32'h0000_0000;
            end
        end
    end

    // ***************************************************
    // Commands
    // ***************************************************
    assign cmd_wr = wr & ((ix == SDBT_IX_CLR) | (ix == SDBT_IX_SET));
    assign cmd    = cmd_wr ? wd[SDBT_CMD_LSB +: 2] : SDBT_CMD_NONE;
    assign do_restart = (cmd == SDBT_CMD_RESTART);
    assign do_hard    = (cmd == SDBT_CMD_HARD) & ~clken_r.enable;

    // Update strobe handed to buffer logic outside
    always_ff @(posedge clk_sys) begin
        if (rst)
            upd_r <= 1'b0;
        else
            upd_r <= (cmd == SDBT_CMD_UPDATE);
    end

    // Status bits: set and clear by ones
    always_ff @(posedge clk_sys) begin
        if (rst || do_hard)
            stat_r <= SDBT_RST_BYTE;
        else if (wr && ix == SDBT_IX_CLR)
            stat_r <= stat_r & ~(wd & SDBT_M_STAT);
        else if (wr && ix == SDBT_IX_SET)
            stat_r <= stat_r | (wd & SDBT_M_STAT);
    end

    // ***************************************************
    // Control registers
    // ***************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clken_r <= SDBT_RST_BYTE;
            split_r <= 1'b0;
        end else if (wr) begin
            if (ix == SDBT_IX_CLKEN)
                clken_r <= wd & SDBT_M_CLKEN;
            if (ix == SDBT_IX_SPLIT)
                split_r <= wd[0];
        end
    end

    // Channel configuration, cleared by hard reset
    always_ff @(posedge clk_sys) begin
        if (rst || do_hard) begin
            cmpen_r <= SDBT_RST_BYTE;
            oval_r  <= SDBT_RST_BYTE;
            inten_r <= SDBT_RST_BYTE;
        end else if (wr) begin
            if (ix == SDBT_IX_CMPEN)
                cmpen_r <= wd & SDBT_M_CHAN;
            if (ix == SDBT_IX_OVAL)
                oval_r <= wd & SDBT_M_CHAN;
            if (ix == SDBT_IX_INTEN)
                inten_r <= wd & SDBT_M_FLAGS;
        end
    end

    // Period and compare values
    always_ff @(posedge clk_sys) begin
        if (rst || do_hard) begin
            per_r[0] <= SDBT_RST_PER;
            per_r[1] <= SDBT_RST_PER;
            for (int n = 0; n < 6; n++)
                cmp_r[n] <= SDBT_RST_BYTE;
        end else if (wr) begin
            if (ix == SDBT_IX_LPER)
                per_r[0] <= wd;
            if (ix == SDBT_IX_HPER)
                per_r[1] <= wd;
            if (cmp_hit_ix)
                cmp_r[cmp_ch] <= wd;
        end
    end

    // ***************************************************
    // Prescaler and counters
    // ***************************************************
    assign running = clken_r.enable & split_r;
    assign tick    = running &
        ((presc_r & SDBT_DIV_MASK[clken_r.prescale_select])
         == 10'h000);

    // Free prescaler, held at zero while stopped
    always_ff @(posedge clk_sys) begin
        if (rst || !running || do_restart)
            presc_r <= 10'h000;
        else
            presc_r <= presc_r + 10'h001;
    end

    // Two byte down-counters; bus write wins
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            if (rst || do_hard) begin
                cnt_r[i] <= SDBT_RST_BYTE;
            end else if (wr && ix == SDBT_IX_LOW_CNT + 6'(i)) begin
                cnt_r[i] <= wd;
            end else if (do_restart) begin
                cnt_r[i] <= per_r[i];
            end else if (tick) begin
                cnt_r[i] <= (cnt_r[i] == 8'h00) ? per_r[i]
                                                : cnt_r[i] - 8'h01;
            end
        end
    end

    // Bottom and compare events
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            unf[i] = tick & (cnt_r[i] == 8'h00);
        end
        for (int n = 0; n < 3; n++) begin
            lmatch[n] = tick & (cnt_r[0] == cmp_r[n]);
        end
    end

    // ***************************************************
    // Flags and interrupt
    // ***************************************************
    always_comb begin
        flags_nxt = flags_r;
        if (wr && ix == SDBT_IX_FLAGS) begin
            flags_nxt = flags_r & ~(wd & SDBT_M_FLAGS);
        end
        flags_nxt[SDBT_F_LOW_UNF] = flags_nxt[SDBT_F_LOW_UNF] | unf[0];
        flags_nxt[SDBT_F_HIGH_UNF] = flags_nxt[SDBT_F_HIGH_UNF] | unf[1];
        flags_nxt[SDBT_F_LCMP +: 3] =
            flags_nxt[SDBT_F_LCMP +: 3] | lmatch;
    end

    // Sticky flags, event beats clear
    always_ff @(posedge clk_sys) begin
        if (rst || do_hard)
            flags_r <= SDBT_RST_BYTE;
        else
            flags_r <= flags_nxt;
    end

    // Level interrupt from enabled flags
    always_ff @(posedge clk_sys) begin
        if (rst)
            irq_r <= 1'b0;
        else
            irq_r <= |(flags_r & inten_r);
    end

    // ***************************************************
    // Waveform outputs
    // ***************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wg_r  <= 6'h00;
            pin_r <= 6'h00;
        end else begin
            for (int n = 0; n < 3; n++) begin
                if (!clken_r.enable) begin
                    wg_r[n]     <= oval_r[n];
                    wg_r[n + 3] <= oval_r[n + 4];
                end else begin
                    wg_r[n]     <= cnt_r[0] < cmp_r[n];
                    wg_r[n + 3] <= cnt_r[1] < cmp_r[n + 3];
                end
                pin_r[n]     <= cmpen_r[n] ? wg_r[n]
                                           : port_out[n];
                pin_r[n + 3] <= cmpen_r[n + 4] ? wg_r[n + 3]
                                               : port_out[n + 3];
            end
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign waveform_pin = pin_r;
    assign update_pulse = upd_r;
    assign irq          = irq_r;

    // ***************************************************
    // Assertions
    // ***************************************************
    property p_div2;
        @(posedge clk_sys) disable iff (rst)
        (tick && clken_r.prescale_select == 3'h1 && !do_restart
         && !wr) |=> !tick;
    endproperty
    a_div2: assert property (p_div2)
        else $error("div2 prescaler ticked twice");
    property p_stop;
        @(posedge clk_sys) disable iff (rst)
        (!clken_r.enable && !wr) |=> cnt_r[0] == $past(cnt_r[0]);
    endproperty
    a_stop: assert property (p_stop)
        else $error("disabled counter moved");
    property p_pin;
        @(posedge clk_sys) disable iff (rst)
        cmpen_r[0] ##1 cmpen_r[0] |-> pin_r[0] == $past(wg_r[0]);
    endproperty
    a_pin: assert property (p_pin)
        else $error("enabled pin not driven by generator");
    property p_idle;
        @(posedge clk_sys) disable iff (rst)
        (!clken_r.enable && cmpen_r[0]) ##1 cmpen_r[0]
        |=> pin_r[0] == $past(oval_r[0], 2);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle level not on pin");
    property p_cmdz;
        @(posedge clk_sys) disable iff (rst)
        (fire && !pwrite && (ix == SDBT_IX_CLR || ix == SDBT_IX_SET))
        |-> prdata_r[3:2] == 2'h0 && prdata_r[7:0] == stat_r;
    endproperty
    a_cmdz: assert property (p_cmdz)
        else $error("command field read nonzero");
    property p_hard;
        @(posedge clk_sys) disable iff (rst)
        (cmd == SDBT_CMD_HARD && clken_r.enable)
        |=> per_r[0] == $past(per_r[0]);
    endproperty
    a_hard: assert property (p_hard)
        else $error("hard reset acted while enabled");
    property p_setclr;
        @(posedge clk_sys) disable iff (rst)
        (wr && ix == SDBT_IX_SET && wd[0] && !do_hard) |=> stat_r[0]
        ##0 (stat_r[1] == $past(stat_r[1]) || $past(wd[1]));
    endproperty
    a_setclr: assert property (p_setclr)
        else $error("status set by one failed");
    property p_w1c;
        @(posedge clk_sys) disable iff (rst)
        (wr && ix == SDBT_IX_FLAGS && wd[0] && !unf[0])
        |=> !flags_r[0];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("flag not cleared by one");
    property p_sticky;
        @(posedge clk_sys) disable iff (rst)
        (flags_r[1] && !do_hard
         && !(wr && ix == SDBT_IX_FLAGS && wd[1])) |=> flags_r[1];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag cleared on its own");
    property p_unf;
        @(posedge clk_sys) disable iff (rst)
        unf[0] |=> flags_r[0] ##1 (irq_r || !$past(inten_r[0]));
    endproperty
    a_unf: assert property (p_unf)
        else $error("underflow flag or interrupt missing");
endmodule : sdbt_timer

// [verilog/sdbt_pkg.sv]
// Constants, field layouts and types of the split-mode dual byte timer
package sdbt_pkg;
    // ***************************************************
    // Register indices (byte address = 4 * index)
    // ***************************************************
    localparam logic [5:0] SDBT_IX_CLKEN  = 6'h00;
    localparam logic [5:0] SDBT_IX_CMPEN  = 6'h01;
    localparam logic [5:0] SDBT_IX_OVAL   = 6'h02;
    localparam logic [5:0] SDBT_IX_SPLIT  = 6'h03;
    localparam logic [5:0] SDBT_IX_CLR    = 6'h04;
    localparam logic [5:0] SDBT_IX_SET    = 6'h05;
    localparam logic [5:0] SDBT_IX_INTEN  = 6'h0a;
    localparam logic [5:0] SDBT_IX_FLAGS  = 6'h0b;
    localparam logic [5:0] SDBT_IX_LOW_CNT = 6'h20;
    localparam logic [5:0] SDBT_IX_HCNT   = 6'h21;
    localparam logic [5:0] SDBT_IX_LPER   = 6'h26;
    localparam logic [5:0] SDBT_IX_HPER   = 6'h27;
    localparam logic [5:0] SDBT_IX_LOW_CMP = 6'h28;
    localparam logic [5:0] SDBT_IX_HCMP   = 6'h29;
    localparam logic [5:0] SDBT_IX_CSTEP  = 6'h02;

    // ***************************************************
    // Field positions, masks and reset values
    // ***************************************************
    localparam int         SDBT_CMD_LSB   = 2;
    localparam int         SDBT_F_LOW_UNF  = 0;
    localparam int         SDBT_F_HIGH_UNF = 1;
    localparam int         SDBT_F_LCMP    = 4;
    localparam logic [7:0] SDBT_M_CLKEN   = 8'h0f;
    localparam logic [7:0] SDBT_M_CHAN    = 8'h77;
    localparam logic [7:0] SDBT_M_SPLIT   = 8'h01;
    localparam logic [7:0] SDBT_M_STAT    = 8'h03;
    localparam logic [7:0] SDBT_M_FLAGS   = 8'h73;
    localparam logic [7:0] SDBT_RST_BYTE  = 8'h00;
    localparam logic [7:0] SDBT_RST_PER   = 8'hff;

    // Prescaler tick masks, divide by 1..1024
    localparam logic [7:0][9:0] SDBT_DIV_MASK = {
        10'h3ff, 10'h0ff, 10'h03f, 10'h00f,
        10'h007, 10'h003, 10'h001, 10'h000};

    // Software commands
    typedef enum logic [1:0] {
        SDBT_CMD_NONE    = 2'h0,
        SDBT_CMD_UPDATE  = 2'h1,
        SDBT_CMD_RESTART = 2'h2,
        SDBT_CMD_HARD    = 2'h3
    } sdbt_cmd_e;

    // Clock select and enable register layout
    typedef struct packed {
        logic [3:0] rsv;
        logic [2:0] prescale_select;
        logic       enable;
    } sdbt_clken_s;
endpackage : sdbt_pkg

// [bench/tb.sv]
// Self-checking testbench of the split-mode dual byte timer over APB
`timescale 1ns/1ps
module tb
    import sdbt_pkg::*;
;
    logic        clk_sys;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  port_out;
    logic [5:0]  waveform_pin;
    logic        update_pulse;
    logic        irq;
    int          n_errors;
    int          checked;
    int          n_upd;

    sdbt_timer i_sdbt_timer (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .port_out     (port_out),
        .waveform_pin (waveform_pin),
        .update_pulse (update_pulse),
        .irq          (irq)
    );

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    // Count update pulses seen
    always @(posedge clk_sys) begin
        if (update_pulse === 1'b1) n_upd++;
    end

    // ***************************************************
    // Report and bus tasks
    // ***************************************************
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [5:0] ix,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {ix, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) begin
            n_errors++;
            $display("wrong value pready expected 1 seen timeout");
            finish_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic wr(input logic [5:0] ix, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, ix, d, r, e);
    endtask : wr

    task automatic rdc(input logic [5:0] ix, input logic [31:0] ex,
                       input string nm);
        logic [31:0] d;
        logic        e;
        apb(1'b0, ix, 8'h00, d, e);
        chk(nm, ex, d);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask : rdc

    task automatic pinchk(input logic [5:0] ex);
        repeat (4) @(posedge clk_sys);
        chk("waveform_pin", {26'h0, ex}, {26'h0, waveform_pin});
    endtask : pinchk

    task automatic irqchk(input logic ex);
        repeat (3) @(posedge clk_sys);
        chk("irq", {31'h0, ex}, {31'h0, irq});
    endtask : irqchk

    // ***************************************************
    // Main sequence
    // ***************************************************
    initial begin
        logic [5:0]  ixs [7];
        logic [5:0]  rwi [4];
        logic [7:0]  rwm [4];
        int          divs [8];
        logic [31:0] d;
        logic        e;
        ixs = '{SDBT_IX_CMPEN, SDBT_IX_OVAL, SDBT_IX_SPLIT, SDBT_IX_CLR,
                SDBT_IX_SET, SDBT_IX_INTEN, SDBT_IX_FLAGS};
        rwi = '{SDBT_IX_CMPEN, SDBT_IX_OVAL, SDBT_IX_SPLIT, SDBT_IX_INTEN};
        rwm = '{SDBT_M_CHAN, SDBT_M_CHAN, SDBT_M_SPLIT, SDBT_M_FLAGS};
        divs = '{1, 2, 4, 8, 16, 64, 256, 1024};
        clk_sys = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        port_out = 6'h00;
        n_errors = 0;
        checked = 0;
        n_upd = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        // Reset values, access masks, unmapped place
        for (int i = 0; i < 7; i++) rdc(ixs[i], 32'h0, "reset value");
        for (int i = 0; i < 4; i++) begin
            wr(rwi[i], 8'hff);
            rdc(rwi[i], {24'h0, rwm[i]}, "register mask");
            wr(rwi[i], 8'h00);
        end
        apb(1'b0, 6'h06, 8'h00, d, e);
        chk("pslverr", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, d);
        // Pin source: port value, idle level
        port_out <= 6'h2a;
        pinchk(6'h2a);
        wr(SDBT_IX_CMPEN, 8'h77);
        wr(SDBT_IX_OVAL, 8'h51);
        pinchk(6'h29);
        wr(SDBT_IX_OVAL, 8'h26);
        pinchk(6'h16);
        wr(SDBT_IX_CMPEN, 8'h70);
        pinchk(6'h12);
        // Status set and clear, command reads, update
        wr(SDBT_IX_SET, 8'h03);
        rdc(SDBT_IX_CLR, 32'h03, "status via clear");
        rdc(SDBT_IX_SET, 32'h03, "status via set");
        wr(SDBT_IX_CLR, 8'h01);
        rdc(SDBT_IX_SET, 32'h02, "status after clear");
        wr(SDBT_IX_SET, 8'h04);
        rdc(SDBT_IX_SET, 32'h02, "command readback");
        chk("update pulses", 32'h1, n_upd);
        // Hard reset refused while enabled, then taken
        wr(SDBT_IX_INTEN, 8'h13);
        wr(SDBT_IX_CLKEN, 8'h01);
        wr(SDBT_IX_SET, 8'h0c);
        rdc(SDBT_IX_CLR, 32'h02, "status kept");
        rdc(SDBT_IX_INTEN, 32'h13, "enables kept");
        wr(SDBT_IX_CLKEN, 8'h00);
        wr(SDBT_IX_SET, 8'h0c);
        rdc(SDBT_IX_SET, 32'h00, "status cleared");
        rdc(SDBT_IX_INTEN, 32'h00, "enables cleared");
        rdc(SDBT_IX_CMPEN, 32'h00, "channels cleared");
        // Restart loads period; no count when off or not split
        wr(SDBT_IX_LPER, 8'h40);
        wr(SDBT_IX_HPER, 8'h50);
        wr(SDBT_IX_CLR, 8'h08);
        rdc(SDBT_IX_LOW_CNT, 32'h40, "low count restart");
        rdc(SDBT_IX_HCNT, 32'h50, "high count restart");
        wr(SDBT_IX_SPLIT, 8'h01);
        repeat (30) @(posedge clk_sys);
        rdc(SDBT_IX_LOW_CNT, 32'h40, "count while off");
        wr(SDBT_IX_SPLIT, 8'h00);
        wr(SDBT_IX_CLKEN, 8'h01);
        repeat (30) @(posedge clk_sys);
        wr(SDBT_IX_CLKEN, 8'h00);
        rdc(SDBT_IX_LOW_CNT, 32'h40, "count not split");
        // Prescaler: each code counts down from 0xff
        wr(SDBT_IX_SPLIT, 8'h01);
        wr(SDBT_IX_LPER, 8'hff);
        for (int c = 0; c < 8; c++) begin
            wr(SDBT_IX_LOW_CNT, 8'hff);
            wr(SDBT_IX_CLKEN, {4'h0, c[2:0], 1'b1});
            repeat (8 * divs[c]) @(posedge clk_sys);
            wr(SDBT_IX_CLKEN, 8'h00);
            apb(1'b0, SDBT_IX_LOW_CNT, 8'h00, d, e);
            // Runs 8 * div + 4 cycles, first tick at once
            chk("prescale cnt", 32'(247 - (divs[c] + 3) / divs[c]), d);
        end
        // Flags from underflow and compare, interrupt masking
        wr(SDBT_IX_LPER, 8'h03);
        wr(SDBT_IX_HPER, 8'h05);
        wr(SDBT_IX_LOW_CMP, 8'h02);
        wr(SDBT_IX_LOW_CMP + SDBT_IX_CSTEP, 8'h01);
        wr(SDBT_IX_LOW_CMP + 6'(2 * SDBT_IX_CSTEP), 8'h03);
        wr(SDBT_IX_LOW_CNT, 8'h00);
        wr(SDBT_IX_HCNT, 8'h00);
        wr(SDBT_IX_FLAGS, 8'h73);
        rdc(SDBT_IX_FLAGS, 32'h00, "flags cleared");
        wr(SDBT_IX_CLKEN, 8'h01);
        repeat (20) @(posedge clk_sys);
        wr(SDBT_IX_CLKEN, 8'h00);
        rdc(SDBT_IX_FLAGS, 32'h73, "flags set");
        irqchk(1'b0);
        wr(SDBT_IX_INTEN, 8'h10);
        irqchk(1'b1);
        wr(SDBT_IX_FLAGS, 8'h00);
        rdc(SDBT_IX_FLAGS, 32'h73, "flags kept");
        wr(SDBT_IX_FLAGS, 8'h10);
        rdc(SDBT_IX_FLAGS, 32'h63, "one flag cleared");
        irqchk(1'b0);
        wr(SDBT_IX_INTEN, 8'h02);
        irqchk(1'b1);
        wr(SDBT_IX_FLAGS, 8'h02);
        irqchk(1'b0);
        wr(SDBT_IX_INTEN, 8'h01);
        irqchk(1'b1);
        wr(SDBT_IX_INTEN, 8'h40);
        irqchk(1'b1);
        finish_test();
    end
endmodule : tb
